// >>> design/ebhg_pkg.sv
/*
  Constants and types for the external bus hold/grant block.
  Assumes one CPU clock of period P; all response figures are in P.
*/
package ebhg_pkg;

  // CPU clock period, one cycle per P
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int P_PERIOD_PS     = 4000;
  localparam int CYC_PER_P       = P_PERIOD_PS / CLK_PERIOD_PS;

  // Response times, in periods P
  localparam int HIZ_MIN_P       = 4;
  localparam int GRANT_MAX_P     = 2;
  localparam int GRANT_OFF_MIN_P = 4;
  localparam int GRANT_OFF_MAX_P = 7;
  localparam int BLZ_MIN_P       = 3;
  localparam int BLZ_MAX_P       = 6;

  // Derived cycle counts
  localparam int HIZ_MIN_CYC     = HIZ_MIN_P * CYC_PER_P;
  localparam int BLZ_EDGE_CYC    = (BLZ_MIN_P + 1) * CYC_PER_P;
  // Two synchroniser flops plus one state update
  localparam int PIPE_LAT        = 3;

  localparam logic [2:0] WAIT_CNT      = 3'(HIZ_MIN_CYC - PIPE_LAT);
  localparam logic [2:0] DRIVE_CNT     = 3'(BLZ_EDGE_CYC - PIPE_LAT);
  localparam logic [2:0] GRANT_OFF_CNT = 3'(BLZ_EDGE_CYC - PIPE_LAT + 1);
  localparam logic [2:0] CNT_MAX       = 3'h7;

  // SDRAM run length protected when burst-of-eight priority is on
  localparam logic [3:0] BURST8_BEATS  = 4'h8;

  // Values after reset
  localparam logic RST_REQ_N   = 1'b1;
  localparam logic RST_GRANT_N = 1'b1;
  localparam logic RST_OE      = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_HIZ,
    ST_GRANT,
    ST_RELEASE
  } ebhg_state_t;

endpackage : ebhg_pkg

// >>> design/ebhg_sync.sv
/*
  Two-flop level synchroniser for one asynchronous pin.
  Assumes the input is a level with no edge faster than two clocks.
*/
`timescale 1ns/100ps
module ebhg_sync
  import ebhg_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta;
  logic next_meta;
  logic next_sync;

  // First stage is read by the second stage only
  always_comb begin
    next_meta = async_in;
    next_sync = meta;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta     <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync;
    end
  end

endmodule : ebhg_sync

// >>> design/ebhg_top.sv
/*
  Hold request / grant logic for the external memory interface.
  Assumes the memory controller reports pending transactions and SDRAM
  runs on the same clock, and stops starting new work while
  hold_pending is high. clk is the CPU clock also driven out as the
  first output clock; pads apply ext_bus_oe to every bus group.
*/
`timescale 1ns/100ps
module ebhg_top
  import ebhg_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic hold_req_n,
  input  wire logic hold_disable,
  input  wire logic sdram_burst8_priority,
  input  wire logic xact_pending,
  input  wire logic sdram_run,
  input  wire logic sdram_beat,
  output logic      bus_hold_grant_n,
  output logic      ext_bus_oe,
  output logic      hold_pending
);

  ebhg_state_t state;
  ebhg_state_t next_state;
  logic [2:0]  cnt;
  logic [2:0]  next_cnt;
  logic [3:0]  beats;
  logic [3:0]  next_beats;
  logic        req_n_s;
  logic        req;
  logic        burst_ok;
  logic        ready;
  logic        next_grant_n;
  logic        next_oe;
  logic        next_pending;
  logic [2:0]  req_age;
  logic [2:0]  next_req_age;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Pin is asynchronous; edges may land in this cycle or the next
  ebhg_sync #(
    .RESET_VAL (RST_REQ_N)
  ) u_req_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in (hold_req_n),
    .sync_out (req_n_s)
  );

  assign req = !req_n_s;

  sync_path_a: assert property (req_n_s == $past(hold_req_n, 2))
    else $error("hold request not synchronised by two flops");

  // Cycles the synchronised request has stood; watched by the float check only
  always_comb begin
    next_req_age = req_age;
    if (!req) begin
      next_req_age = 3'h0;
    end else if (req_age != CNT_MAX) begin
      next_req_age = req_age + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_age <= 3'h0;
    end else begin
      req_age <= next_req_age;
    end
  end

  // Count SDRAM accesses in the current run, saturating at eight
  always_comb begin
    next_beats = beats;
    if (!sdram_run) begin
      next_beats = 4'h0;
    end else if (sdram_beat && (beats < BURST8_BEATS)) begin
      next_beats = beats + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      beats <= 4'h0;
    end else begin
      beats <= next_beats;
    end
  end

  // A run shorter than eight would waste its row open; let it finish
  assign burst_ok = !sdram_burst8_priority || !sdram_run || (beats >= BURST8_BEATS);

  // Release only when nothing is in flight and hold is allowed
  assign ready = !xact_pending && burst_ok && !hold_disable;

  // Hold sequencer with its cycle counter and registered outputs
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (req) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!req) begin
          next_state = ST_IDLE;
        end else if ((cnt >= WAIT_CNT) && ready) begin
          next_state = ST_HIZ;
        end
      end
      ST_HIZ: begin
        next_state = ST_GRANT;
      end
      ST_GRANT: begin
        if (!req) begin
          next_state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (cnt >= GRANT_OFF_CNT) begin
          next_state = ST_IDLE;
        end
      end
      // Unused codes fall back to a driven, ungranted bus
      default: begin
        next_state = ST_IDLE;
      end
    endcase

    // Counter restarts on every state change
    if (next_state != state) begin
      next_cnt = 3'h0;
    end else if (cnt != CNT_MAX) begin
      next_cnt = cnt + 3'h1;
    end else begin
      next_cnt = cnt;
    end

    // A single enable keeps all bus groups switching together
    // Release count only once inside release; the grant's count is stale
    next_oe = (next_state == ST_IDLE) || (next_state == ST_WAIT) ||
              ((next_state == ST_RELEASE) && (state == ST_RELEASE) &&
               (cnt >= DRIVE_CNT));
    next_grant_n = !((next_state == ST_GRANT) || (next_state == ST_RELEASE));
    next_pending = (next_state != ST_IDLE);
  end

  // Registered on the CPU clock so pins stay aligned to its rising edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state            <= ST_IDLE;
      cnt              <= 3'h0;
      ext_bus_oe       <= RST_OE;
      bus_hold_grant_n <= RST_GRANT_N;
      hold_pending     <= 1'b0;
    end else begin
      state            <= next_state;
      cnt              <= next_cnt;
      ext_bus_oe       <= next_oe;
      bus_hold_grant_n <= next_grant_n;
      hold_pending     <= next_pending;
    end
  end

  hiz_min_a: assert property ($fell(ext_bus_oe) |-> !$past(hold_req_n, 4))
    else $error("bus floated less than four periods after request");

  hold_long_a: assert property (
    $fell(ext_bus_oe) |-> (int'($past(req_age)) + PIPE_LAT - 1 >= HIZ_MIN_CYC))
    else $error("request had not stood four periods at bus float");

  grant_after_hiz_a: assert property ($fell(ext_bus_oe) |=> $fell(bus_hold_grant_n))
    else $error("grant did not follow bus float by one period");

  grant_release_a: assert property (
    (!bus_hold_grant_n && state == ST_GRANT && $rose(hold_req_n)) |->
      ##6 $rose(bus_hold_grant_n))
    else $error("grant not removed six periods after request drop");

  bus_resume_a: assert property (
    (!bus_hold_grant_n && state == ST_GRANT && $rose(hold_req_n)) |->
      (!ext_bus_oe)[*5] ##1 ext_bus_oe)
    else $error("bus not driven again five periods after request drop");

  drain_first_a: assert property ($fell(ext_bus_oe) |-> !$past(xact_pending))
    else $error("bus floated while a transaction was pending");

  burst_run_a: assert property (
    ($fell(ext_bus_oe) && $past(sdram_burst8_priority && sdram_run)) |->
      ($past(beats) >= BURST8_BEATS))
    else $error("SDRAM run cut short of eight accesses");

  min_delay_a: assert property (
    ($fell(hold_req_n) && state == ST_IDLE) ##1
      (!hold_req_n && !xact_pending && !hold_disable && !sdram_run)[*4] |=>
      !ext_bus_oe)
    else $error("idle bus not released with minimum delay");

  no_grant_disabled_a: assert property ($fell(ext_bus_oe) |-> !$past(hold_disable))
    else $error("bus released while hold disabled");

  group_float_a: assert property ((!bus_hold_grant_n && state != ST_RELEASE) |-> !ext_bus_oe)
    else $error("bus driven while hold granted");

  edge_order_a: assert property ($changed(bus_hold_grant_n) |-> !$changed(ext_bus_oe))
    else $error("grant and bus enable switched on the same edge");

  full_hold_c: cover property ($fell(bus_hold_grant_n) ##[1:50] $rose(bus_hold_grant_n));
  deferred_c: cover property ((state == ST_WAIT && hold_disable) [*8]);
  burst_wait_c: cover property (state == ST_WAIT && sdram_run && !burst_ok ##1 burst_ok);
  withdrawn_c: cover property (state == ST_WAIT ##1 state == ST_IDLE);

endmodule : ebhg_top

// >>> design/ebhg_placeholder_none.sv
/*
  Intentionally empty compile unit: no further logic for this block.
  Assumes nothing.
*/
`timescale 1ns/100ps

// >>> tb/ebhg_master.sv
/*
  Model of the outside master that borrows the memory bus.
  Assumes want comes from the bench on rising clk edges.
*/
`timescale 1ns/100ps
module ebhg_master (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic want,
  input  wire logic bus_hold_grant_n,
  output logic      hold_req_n,
  output logic      master_oe
);
  logic own;

  // Bus let go in the same step as the request, never after it
  assign hold_req_n = ~want;
  assign master_oe  = want & own;

  // Drive only from the edge after the grant is seen low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      own <= 1'b0;
    else
      own <= want & ~bus_hold_grant_n;
  end
endmodule : ebhg_master

// >>> tb/tb_top.sv
/*
  Self-checking bench for the hold/grant block.
  Assumes the package, the design and the master model compile first.
*/
`timescale 1ns/100ps
module tb_top;
  import ebhg_pkg::*;
  typedef struct {int lo; int hi; logic hp;} ebhg_exp_t;
  logic clk = 1'b0, reset_n = 1'b0, want = 1'b0, hold_disable = 1'b0;
  logic sdram_burst8_priority = 1'b0, xact_pending = 1'b0;
  logic sdram_run = 1'b0, sdram_beat = 1'b0, hold_req_n, master_oe;
  logic bus_hold_grant_n, ext_bus_oe, hold_pending, last_g, last_oe;
  int   mismatches = 0, n_checks = 0, cyc = 0, t_ref = 0, seed = 23, i, d;
  ebhg_exp_t q[$];
  ebhg_exp_t e;

  always #2 clk = ~clk;

  ebhg_master u_mst (.clk(clk), .reset_n(reset_n), .want(want),
    .bus_hold_grant_n(bus_hold_grant_n), .hold_req_n(hold_req_n),
    .master_oe(master_oe));
  ebhg_top u_dut (.clk(clk), .reset_n(reset_n), .hold_req_n(hold_req_n),
    .hold_disable(hold_disable), .sdram_burst8_priority(sdram_burst8_priority),
    .xact_pending(xact_pending), .sdram_run(sdram_run), .sdram_beat(sdram_beat),
    .bus_hold_grant_n(bus_hold_grant_n), .ext_bus_oe(ext_bus_oe),
    .hold_pending(hold_pending));

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic note(int lo, int hi, logic hp);
    q.push_back('{lo, hi, hp});
  endtask : note

  // Bounded wait until the monitor has taken every note
  task automatic drain;
    for (i = 0; i < 60 && q.size() > 0; i++)
      @(posedge clk);
    if (q.size() > 0) begin
      chk("notes left", 0, q.size());
      tally_and_finish;
    end
  endtask : drain

  // Delays count edges from the edge that drove the cause
  task automatic mark;
    t_ref = cyc;
  endtask : mark

  task automatic take;
    @(posedge clk);
    want <= 1'b1;
    mark;
    note(5, 5, 1'b1);
    note(6, 6, 1'b1);
    drain;
  endtask : take

  task automatic give_back;
    @(posedge clk);
    want <= 1'b0;
    mark;
    note(5, 5, 1'b1);
    note(6, 6, 1'b0);
    drain;
  endtask : give_back

  // Blocker just cleared: float soon, grant one edge behind
  task automatic unblocked;
    mark;
    note(1, 4, 1'b1);
    note(2, 5, 1'b1);
    drain;
  endtask : unblocked

  // Each pin change takes the oldest note; a change with none is wrong
  always @(negedge clk) begin
    if (reset_n && (bus_hold_grant_n !== last_g || ext_bus_oe !== last_oe)) begin
      d = cyc - t_ref;
      if (q.size() == 0)
        chk("unexpected change", 0, d);
      else begin
        e = q.pop_front();
        chk("change delay", e.lo, (d >= e.lo && d <= e.hi) ? e.lo : d);
        chk("hold_pending", e.hp, hold_pending);
      end
    end
    chk("bus contention", 0, master_oe & ext_bus_oe);
    last_g = bus_hold_grant_n;
    last_oe = ext_bus_oe;
    cyc++;
  end

  initial begin
    tick(10);
    reset_n <= 1'b1;
    tick(2);
    chk("grant after reset", 1, bus_hold_grant_n);
    // Request dropped before the float: only hold_pending blips
    want <= 1'b1;
    tick(1);
    want <= 1'b0;
    tick(2);
    @(negedge clk);
    chk("pending on short request", 1, hold_pending);
    @(negedge clk);
    chk("pending after withdraw", 0, hold_pending);
    // Idle bus, random hold lengths
    repeat (3) begin
      take;
      tick(2 + ($random(seed) & 15));
      give_back;
    end
    // Pending transfer holds the grant off
    xact_pending <= 1'b1;
    want <= 1'b1;
    tick(8 + ($random(seed) & 7));
    xact_pending <= 1'b0;
    unblocked;
    give_back;
    // Hold disabled: nothing may move for a long stretch
    hold_disable <= 1'b1;
    want <= 1'b1;
    tick(40);
    hold_disable <= 1'b0;
    unblocked;
    give_back;
    // Burst-of-eight: seven beats are not enough
    sdram_burst8_priority <= 1'b1;
    sdram_run <= 1'b1;
    want <= 1'b1;
    repeat (7) begin
      tick(1 + ($random(seed) & 3));
      sdram_beat <= 1'b1;
      tick(1);
      sdram_beat <= 1'b0;
    end
    tick(2);
    sdram_beat <= 1'b1;
    tick(1);
    sdram_beat <= 1'b0;
    unblocked;
    sdram_run <= 1'b0;
    give_back;
    tick(5);
    tally_and_finish;
  end
endmodule : tb_top
